/* File: inc/usm_pkg.sv */
package usm_pkg;
   // Receiver oversampling and frame shape.
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] BIT_LAST = 4'hf;
   localparam logic [2:0] DATA_LAST = 3'h7;
   localparam logic [3:0] SPI_EDGE_LAST = 4'hf;
   localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
   // Line driver mode field encodings.
   localparam logic [1:0] LD_MODE_OFF = 2'h0;
   localparam logic [1:0] LD_MODE_DRIVER = 2'h1;
   localparam logic [1:0] LD_MODE_TXCTRL = 2'h2;
   // System sleep state as seen by the block.
   localparam logic [1:0] SLEEP_ACTIVE = 2'h0;
   localparam logic [1:0] SLEEP_IDLE = 2'h1;
   localparam logic [1:0] SLEEP_STANDBY = 2'h2;
   localparam logic [1:0] SLEEP_PDOWN = 2'h3;
   // Reset values of the data paths.
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [3:0] COUNT_RESET = 4'h0;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_GUARD = 3'b001,
      TX_START = 3'b010,
      TX_DATA = 3'b011,
      TX_STOP = 3'b100,
      TX_SPI = 3'b101
   } usm_tx_e;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } usm_rx_e;
endpackage

/* File: design/usm_sync.sv */
`timescale 1ns/1ns
module usm_sync (
   // Clock and reset.
   input logic ref_clk,
   input logic rst,
   // Asynchronous level in, synchronised level out.
   input logic asyncIn,
   output logic syncOut
);
   logic stage1_reg;
   logic stage2_reg;

   // Pins idle high, so both stages reset to the idle level.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stage1_reg <= 1'b1;
         stage2_reg <= 1'b1;
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;
endmodule // usm_sync

/* File: design/usm_baud.sv */
`timescale 1ns/1ns
module usm_baud #(
   parameter int DIV_WIDTH = 16
) (
   // Clock and reset.
   input logic ref_clk,
   input logic rst,
   // Divisor: one tick every divisor plus one cycles.
   input logic [DIV_WIDTH-1:0] divisor,
   output logic tick
);
   logic [DIV_WIDTH-1:0] count_reg;
   logic tick_reg;
   logic wrap;

   assign wrap = (count_reg >= divisor);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         count_reg <= wrap ? '0 : count_reg + 1'b1;
         tick_reg <= wrap;
      end
   end

   assign tick = tick_reg;
endmodule // usm_baud

/* File: design/usm_top.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - SPI master needs transmitter; receiver optional
// - Master drives transfer clock pin
// - Every transfer starts from data write
// - Data waits in buffer until shifter free
// - Flags as UART; error flags read zero
// - Phase and order match standard SPI master
// - No write collision detection
// - No double speed; use baud divisor
// - No slave select; master directions only
// - Disabling tx/rx same as UART mode
// - Mode 1 direction output, 2 pin control
// - Direction high while UART transmitter active; low in SPI
// - Direction rises one bit before data
// - Direction high through all stop bits
// - Start detect only async and standby
// - Falling edge powers oscillator and clock
// - False start switches clock back off
// - Enable bit; detected start sets flag
// - Detection off in active, idle, powerdown
// - Two flags share one interrupt line
// - Enables decide which event wakes clocks
// - Sleep keeps oscillator during communication
module usm_top #(
   parameter int DIV_WIDTH = 16
) (
   // Clock and reset.
   input logic ref_clk,
   input logic rst,
   // Configuration.
   input logic txEnable,
   input logic rxEnable,
   input logic spiMode,
   input logic clockPhaseSel,
   input logic bitOrderSel,
   input logic [1:0] lineDriverMode,
   input logic twoStopBits,
   input logic [DIV_WIDTH-1:0] baudDivisor,
   input logic startDetectEnable,
   input logic rxCompleteIntEn,
   input logic startDetectIntEn,
   // System power state.
   input logic [1:0] sleepMode,
   input logic otherWake,
   // Transmit data.
   input logic [7:0] txDataReg,
   input logic txDataRegWrite,
   output logic dataRegEmpty,
   // Receive data and flags.
   output logic [7:0] rxData,
   input logic rxRead,
   output logic rxCompleteFlag,
   output logic frameError,
   output logic bufferOverflow,
   output logic startDetectFlag,
   input logic startDetectClear,
   // Shared interrupt and power requests.
   output logic rxIrq,
   output logic wakeRequest,
   output logic oscRequest,
   output logic serialClkEnable,
   // Pins.
   input logic rxdPin,
   output logic txdOut,
   output logic txdOeN,
   output logic txDirectionOut,
   output logic transferClockPinOut,
   output logic transferClockPinOeN
);
   usm_pkg::usm_tx_e txState_reg;
   usm_pkg::usm_rx_e rxState_reg;
   logic baudTick;
   logic rxdSync;
   logic rxdPrev_reg;
   logic [7:0] txBuf_reg;
   logic dataRegEmpty_reg;
   logic [7:0] txShift_reg;
   logic [3:0] txTick_reg;
   logic [2:0] txBitCnt_reg;
   logic [3:0] edgeCnt_reg;
   logic secondStop_reg;
   logic txdOut_reg;
   logic txdOeN_reg;
   logic txDirectionOut_reg;
   logic transferClockOut_reg;
   logic transferClockOeN_reg;
   logic [7:0] rxShift_reg;
   logic [3:0] rxTick_reg;
   logic [2:0] rxBitCnt_reg;
   logic [7:0] rxData_reg;
   logic rxCompleteFlag_reg;
   logic frameError_reg;
   logic bufferOverflow_reg;
   logic startDetectFlag_reg;
   logic sfdClk_reg;
   logic rxIrq_reg;
   logic wakeRequest_reg;
   logic oscRequest_reg;
   logic serialClkEnable_reg;

   function automatic logic outBit(input logic [7:0] v, input logic lsbFirst);
      outBit = lsbFirst ? v[0] : v[7];
   endfunction

   function automatic logic [7:0] shifted(input logic [7:0] v, input logic lsbFirst);
      shifted = lsbFirst ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic b,
                                          input logic lsbFirst);
      shiftIn = lsbFirst ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   // The baud divisor alone sets the rate; there is no double speed option.
   usm_baud #(.DIV_WIDTH(DIV_WIDTH)) baudGen (
      .ref_clk(ref_clk),
      .rst(rst),
      .divisor(baudDivisor),
      .tick(baudTick)
   );

   usm_sync rxdSyncer (
      .ref_clk(ref_clk),
      .rst(rst),
      .asyncIn(rxdPin),
      .syncOut(rxdSync)
   );

   // Decoding of the transmit side.
   logic txBitEnd;
   logic stopMore;
   logic txFrameEnd;
   logic txLoad;
   logic txWriteOk;
   logic ldOn;
   logic spiLeadEdge;
   logic spiSample;
   logic spiShiftOut;
   logic spiDone;
   logic dirNext;
   assign txBitEnd = baudTick && (txTick_reg == usm_pkg::BIT_LAST);
   assign stopMore = twoStopBits && !secondStop_reg;
   assign txFrameEnd = (txState_reg == usm_pkg::TX_STOP) && txBitEnd && !stopMore;
   // A pending word moves only when the shifter is free.
   assign txLoad = !dataRegEmpty_reg && ((txState_reg == usm_pkg::TX_IDLE) || txFrameEnd);
   // A write while full is dropped silently; no collision flag exists.
   assign txWriteOk = txDataRegWrite && dataRegEmpty_reg && txEnable;
   assign ldOn = (lineDriverMode != usm_pkg::LD_MODE_OFF);
   // Direction follows the registered state, as the data pin does, so it leads the
   // start bit by the guard bit, which can be up to one baud tick short of a full bit, and falls with the end of the last stop bit.
   assign dirNext = ldOn && (txState_reg != usm_pkg::TX_IDLE) &&
                    (txState_reg != usm_pkg::TX_SPI);
   assign spiLeadEdge = !edgeCnt_reg[0];
   // Phase select picks which edge samples, as on a standard SPI master.
   assign spiSample = (txState_reg == usm_pkg::TX_SPI) && baudTick &&
                      (spiLeadEdge != clockPhaseSel);
   assign spiShiftOut = (txState_reg == usm_pkg::TX_SPI) && baudTick &&
                        (spiLeadEdge == clockPhaseSel) && (edgeCnt_reg != usm_pkg::SPI_EDGE_LAST);
   assign spiDone = (txState_reg == usm_pkg::TX_SPI) && baudTick &&
                    (edgeCnt_reg == usm_pkg::SPI_EDGE_LAST);

   // Transmit buffer; writing it is what starts every transfer.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         txBuf_reg <= usm_pkg::DATA_RESET;
         dataRegEmpty_reg <= 1'b1;
      end else if (txWriteOk) begin
         txBuf_reg <= txDataReg;
         dataRegEmpty_reg <= 1'b0;
      end else if (txLoad) begin
         dataRegEmpty_reg <= 1'b1;
      end
   end

   // Transmitter. Pending data is always finished, even after disable.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         txState_reg <= usm_pkg::TX_IDLE;
         txShift_reg <= usm_pkg::DATA_RESET;
         txTick_reg <= usm_pkg::COUNT_RESET;
         txBitCnt_reg <= 3'h0;
         edgeCnt_reg <= usm_pkg::COUNT_RESET;
         secondStop_reg <= 1'b0;
         txdOut_reg <= 1'b1;
         txDirectionOut_reg <= 1'b0;
         transferClockOut_reg <= 1'b0;
      end else begin
         if (baudTick) begin
            txTick_reg <= txTick_reg + 4'h1;
         end
         case (txState_reg)
            usm_pkg::TX_IDLE: begin
               txTick_reg <= usm_pkg::COUNT_RESET;
               edgeCnt_reg <= usm_pkg::COUNT_RESET;
               transferClockOut_reg <= 1'b0;
               if (txLoad && spiMode) begin
                  txState_reg <= usm_pkg::TX_SPI;
                  if (!clockPhaseSel) begin
                     txdOut_reg <= outBit(txBuf_reg, bitOrderSel);
                     txShift_reg <= shifted(txBuf_reg, bitOrderSel);
                  end else begin
                     txShift_reg <= txBuf_reg;
                  end
               end else if (txLoad) begin
                  txShift_reg <= txBuf_reg;
                  // Guard bit lets the external driver turn on first.
                  txState_reg <= ldOn ? usm_pkg::TX_GUARD : usm_pkg::TX_START;
               end else begin
                  txdOut_reg <= 1'b1;
               end
            end
            usm_pkg::TX_GUARD: begin
               txdOut_reg <= 1'b1;
               if (txBitEnd) begin
                  txState_reg <= usm_pkg::TX_START;
               end
            end
            usm_pkg::TX_START: begin
               txdOut_reg <= 1'b0;
               txBitCnt_reg <= 3'h0;
               secondStop_reg <= 1'b0;
               if (txBitEnd) begin
                  txState_reg <= usm_pkg::TX_DATA;
               end
            end
            usm_pkg::TX_DATA: begin
               txdOut_reg <= txShift_reg[0];
               if (txBitEnd) begin
                  txShift_reg <= shifted(txShift_reg, 1'b1);
                  txBitCnt_reg <= txBitCnt_reg + 3'h1;
                  if (txBitCnt_reg == usm_pkg::DATA_LAST) begin
                     txState_reg <= usm_pkg::TX_STOP;
                  end
               end
            end
            usm_pkg::TX_STOP: begin
               txdOut_reg <= 1'b1;
               // Direction stays up over every stop bit.
               if (txBitEnd && stopMore) begin
                  secondStop_reg <= 1'b1;
               end else if (txFrameEnd && txLoad) begin
                  txShift_reg <= txBuf_reg;
                  txState_reg <= usm_pkg::TX_START;
               end else if (txFrameEnd) begin
                  txState_reg <= usm_pkg::TX_IDLE;
               end
            end
            usm_pkg::TX_SPI: begin
               // The transmitter owns the transfer clock, so it is driven here.
               if (baudTick) begin
                  edgeCnt_reg <= edgeCnt_reg + 4'h1;
                  transferClockOut_reg <= !transferClockOut_reg;
               end
               if (spiShiftOut) begin
                  txdOut_reg <= outBit(txShift_reg, bitOrderSel);
                  txShift_reg <= shifted(txShift_reg, bitOrderSel);
               end
               if (spiDone) begin
                  txState_reg <= usm_pkg::TX_IDLE;
               end
            end
            default: begin
               txState_reg <= usm_pkg::TX_IDLE;
            end
         endcase
         txDirectionOut_reg <= dirNext;
      end
   end

   // Pin ownership. Mode 2 releases the data pin whenever nothing is sent.
   logic txActive;
   logic txdDrive;
   assign txActive = (txState_reg != usm_pkg::TX_IDLE) || txLoad;
   assign txdDrive = (lineDriverMode == usm_pkg::LD_MODE_TXCTRL) ? txActive :
                     (txEnable || txActive || !dataRegEmpty_reg);

   // Only data out, data in and clock exist; there is no slave select.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         txdOeN_reg <= 1'b1;
         transferClockOeN_reg <= 1'b1;
      end else begin
         txdOeN_reg <= !txdDrive;
         transferClockOeN_reg <= !spiMode;
      end
   end

   // Receive side decoding. The receiver is only a serial input in SPI mode.
   logic rxRun;
   logic rxFall;
   logic falseStart;
   logic uartSample;
   logic uartDone;
   logic rxLoad;
   logic [7:0] rxShiftNext;
   logic sfdActive;
   logic sfdStart;
   assign rxRun = rxEnable && !spiMode;
   assign rxFall = rxdPrev_reg && !rxdSync;
   assign falseStart = (rxState_reg == usm_pkg::RX_START) && baudTick &&
                       (rxTick_reg == usm_pkg::SAMPLE_MID) && rxdSync;
   assign uartSample = (rxState_reg == usm_pkg::RX_DATA) && baudTick &&
                       (rxTick_reg == usm_pkg::BIT_LAST);
   assign uartDone = (rxState_reg == usm_pkg::RX_STOP) && baudTick &&
                     (rxTick_reg == usm_pkg::BIT_LAST);
   assign rxLoad = uartDone || (spiDone && rxEnable);
   assign rxShiftNext = spiSample ? shiftIn(rxShift_reg, rxdSync, bitOrderSel) :
                        uartSample ? shiftIn(rxShift_reg, rxdSync, 1'b1) : rxShift_reg;
   // Detection only in async mode and standby; otherwise it is off.
   assign sfdActive = startDetectEnable && !spiMode && (sleepMode == usm_pkg::SLEEP_STANDBY);
   assign sfdStart = sfdActive && rxRun && (rxState_reg == usm_pkg::RX_IDLE) && rxFall;

   // Asynchronous receiver; disabling it aborts the frame at once.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rxState_reg <= usm_pkg::RX_IDLE;
         rxTick_reg <= usm_pkg::COUNT_RESET;
         rxBitCnt_reg <= 3'h0;
         rxShift_reg <= usm_pkg::DATA_RESET;
         rxdPrev_reg <= 1'b1;
      end else begin
         rxdPrev_reg <= rxdSync;
         rxShift_reg <= rxShiftNext;
         if (baudTick) begin
            rxTick_reg <= rxTick_reg + 4'h1;
         end
         case (rxState_reg)
            usm_pkg::RX_IDLE: begin
               rxTick_reg <= usm_pkg::COUNT_RESET;
               if (rxRun && rxFall) begin
                  rxState_reg <= usm_pkg::RX_START;
               end
            end
            usm_pkg::RX_START: begin
               if (baudTick && (rxTick_reg == usm_pkg::SAMPLE_MID)) begin
                  rxTick_reg <= usm_pkg::COUNT_RESET;
                  rxBitCnt_reg <= 3'h0;
                  rxState_reg <= rxdSync ? usm_pkg::RX_IDLE : usm_pkg::RX_DATA;
               end
            end
            usm_pkg::RX_DATA: begin
               if (uartSample) begin
                  rxBitCnt_reg <= rxBitCnt_reg + 3'h1;
                  if (rxBitCnt_reg == usm_pkg::DATA_LAST) begin
                     rxState_reg <= usm_pkg::RX_STOP;
                  end
               end
            end
            usm_pkg::RX_STOP: begin
               if (uartDone) begin
                  rxState_reg <= usm_pkg::RX_IDLE;
               end
            end
            default: begin
               rxState_reg <= usm_pkg::RX_IDLE;
            end
         endcase
         if (!rxRun) begin
            rxState_reg <= usm_pkg::RX_IDLE;
         end
      end
   end

   // Receive buffer and flags. A new frame wins over a read in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (rst || !rxEnable) begin
         rxData_reg <= usm_pkg::DATA_RESET;
         rxCompleteFlag_reg <= 1'b0;
         frameError_reg <= 1'b0;
         bufferOverflow_reg <= 1'b0;
      end else if (rxLoad) begin
         rxData_reg <= rxShiftNext;
         rxCompleteFlag_reg <= 1'b1;
         // Error flags are unused in SPI mode and stay zero there.
         frameError_reg <= uartDone && !rxdSync;
         bufferOverflow_reg <= !spiMode && rxCompleteFlag_reg && !rxRead;
      end else if (rxRead) begin
         rxCompleteFlag_reg <= 1'b0;
         frameError_reg <= 1'b0;
         bufferOverflow_reg <= 1'b0;
      end
   end

   // Start detection flag and the clock request it raises.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         startDetectFlag_reg <= 1'b0;
         sfdClk_reg <= 1'b0;
      end else begin
         startDetectFlag_reg <= sfdStart || (startDetectFlag_reg && !startDetectClear);
         if (sfdStart) begin
            sfdClk_reg <= 1'b1;
         end else if ((falseStart && !otherWake) || rxLoad || !sfdActive) begin
            sfdClk_reg <= 1'b0;
         end
      end
   end

   // Shared interrupt line and power requests.
   logic irqNext;
   logic sysAwake;
   logic commBusy;
   assign irqNext = (rxCompleteFlag_reg && rxCompleteIntEn) ||
                    (startDetectFlag_reg && startDetectIntEn);
   assign sysAwake = (sleepMode == usm_pkg::SLEEP_ACTIVE) || (sleepMode == usm_pkg::SLEEP_IDLE);
   assign commBusy = (txState_reg != usm_pkg::TX_IDLE) || (rxState_reg != usm_pkg::RX_IDLE) ||
                     !dataRegEmpty_reg;

   // With both enables off nothing wakes the system; frames in standby are still received into the buffer.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rxIrq_reg <= 1'b0;
         wakeRequest_reg <= 1'b0;
         oscRequest_reg <= 1'b1;
         serialClkEnable_reg <= 1'b1;
      end else begin
         rxIrq_reg <= irqNext;
         wakeRequest_reg <= irqNext && !sysAwake;
         oscRequest_reg <= sysAwake || commBusy || sfdClk_reg;
         serialClkEnable_reg <= sysAwake || commBusy || sfdClk_reg;
      end
   end

   assign dataRegEmpty = dataRegEmpty_reg;
   assign rxData = rxData_reg;
   assign rxCompleteFlag = rxCompleteFlag_reg;
   assign frameError = frameError_reg;
   assign bufferOverflow = bufferOverflow_reg;
   assign startDetectFlag = startDetectFlag_reg;
   assign rxIrq = rxIrq_reg;
   assign wakeRequest = wakeRequest_reg;
   assign oscRequest = oscRequest_reg;
   assign serialClkEnable = serialClkEnable_reg;
   assign txdOut = txdOut_reg;
   assign txdOeN = txdOeN_reg;
   assign txDirectionOut = txDirectionOut_reg;
   assign transferClockPinOut = transferClockOut_reg;
   assign transferClockPinOeN = transferClockOeN_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   spi_needs_tx_a: assert property ((txState_reg == usm_pkg::TX_IDLE) && dataRegEmpty_reg &&
      !txEnable |=> txState_reg != usm_pkg::TX_SPI) else $error("SPI began without tx");
   clk_idle_low_a: assert property ((txState_reg == usm_pkg::TX_IDLE) |->
      !transferClockOut_reg) else $error("Transfer clock not low when idle");
   start_on_write_a: assert property ((txState_reg == usm_pkg::TX_IDLE) && dataRegEmpty_reg
      |=> txState_reg == usm_pkg::TX_IDLE) else $error("Transfer without data");
   buffer_hold_a: assert property (!dataRegEmpty_reg && (txState_reg == usm_pkg::TX_DATA)
      && !txDataRegWrite |=> !dataRegEmpty_reg) else $error("Buffer left early");
   spi_no_errors_a: assert property (spiMode && $past(spiMode) |->
      !frameError_reg && !bufferOverflow_reg) else $error("Error flag in SPI mode");
   dir_guard_a: assert property ($rose(txDirectionOut_reg) |->
      (txState_reg == usm_pkg::TX_GUARD) && txdOut_reg) else $error("No guard bit");
   dir_frame_a: assert property (ldOn && $stable(lineDriverMode) &&
      ((txState_reg == usm_pkg::TX_STOP) || (txState_reg == usm_pkg::TX_DATA)) |->
      txDirectionOut_reg) else $error("Direction low in frame");
   dir_release_a: assert property ((txState_reg == usm_pkg::TX_IDLE) &&
      $past(txState_reg == usm_pkg::TX_IDLE) |-> !txDirectionOut_reg)
      else $error("Direction high after frame");
   sfd_standby_a: assert property ($rose(startDetectFlag_reg) |-> $past(sfdActive))
      else $error("Start flag outside standby");
   false_start_a: assert property (falseStart && !otherWake && !sfdStart |=> !sfdClk_reg)
      else $error("Clock kept after false start");
   osc_busy_a: assert property ((txState_reg != usm_pkg::TX_IDLE) |=> oscRequest_reg)
      else $error("Oscillator dropped while busy");

   spi_done_c: cover property (spiDone && rxEnable);
   line_frame_c: cover property (txFrameEnd && txDirectionOut_reg);
   sfd_wake_c: cover property (sfdStart ##[1:40] wakeRequest_reg);
   false_start_c: cover property (falseStart && sfdClk_reg);
endmodule // usm_top

/* File: verification/usm_spi_slave.sv */
`timescale 1ns/1ns
module usm_spi_slave (
   // Serial lines.
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // Setup and captured byte.
   input wire logic cpha,
   input wire logic lsbFirst,
   input wire logic [7:0] txByte,
   input wire logic load,
   output logic [7:0] rxByte
);
   int n = 0;
   int idx;
   always_comb idx = cpha ? n - 1 : n;
   // Outside the eight bit slots the line toggles, so a late sample cannot pass by luck.
   assign miso = (idx < 0 || idx > 7) ? n[0] : txByte[lsbFirst ? idx : 7 - idx];
   // Shift on the edge opposite the sampling edge, as a real slave does.
   always @(posedge load or sck) begin
      if (load) n = 0;
      else if (sck === cpha) n++;
      else rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
   end
endmodule // usm_spi_slave

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   logic ref_clk = 1'h0, rst = 1'h1, txEnable = 1'h1, rxEnable = 1'h1, spiMode = 1'h1;
   logic clockPhaseSel = 1'h0, bitOrderSel = 1'h0, twoStopBits = 1'h1, startDetectEnable = 1'h0;
   logic rxCompleteIntEn = 1'h1, startDetectIntEn = 1'h1, otherWake = 1'h0;
   logic txDataRegWrite = 1'h0, rxRead = 1'h0, startDetectClear = 1'h0, uartLine = 1'h1;
   logic load = 1'h0, rxdPin, miso, dataRegEmpty, rxCompleteFlag, frameError;
   logic bufferOverflow, startDetectFlag, rxIrq, wakeRequest, oscRequest, serialClkEnable;
   logic txdOut, txdOeN, txDirectionOut, transferClockPinOut, transferClockPinOeN;
   logic [1:0] lineDriverMode = 2'h0, sleepMode = 2'h0;
   logic [15:0] baudDivisor = 16'h0007;
   logic [7:0] txDataReg = 8'h00, rxData, slaveTx, slaveRx, got;
   int n_fail = 0, check_count = 0, c;
   assign rxdPin = spiMode ? miso : uartLine;
   usm_top u_usm_top (.ref_clk, .rst, .txEnable, .rxEnable, .spiMode, .clockPhaseSel,
      .bitOrderSel, .lineDriverMode, .twoStopBits, .baudDivisor, .startDetectEnable,
      .rxCompleteIntEn, .startDetectIntEn, .sleepMode, .otherWake, .txDataReg,
      .txDataRegWrite, .dataRegEmpty, .rxData, .rxRead, .rxCompleteFlag, .frameError,
      .bufferOverflow, .startDetectFlag, .startDetectClear, .rxIrq, .wakeRequest,
      .oscRequest, .serialClkEnable, .rxdPin, .txdOut, .txdOeN, .txDirectionOut,
      .transferClockPinOut, .transferClockPinOeN);
   usm_spi_slave u_usm_spi_slave (.sck(transferClockPinOut), .mosi(txdOut), .miso(miso),
      .cpha(clockPhaseSel), .lsbFirst(bitOrderSel), .txByte(slaveTx), .load(load),
      .rxByte(slaveRx));
   initial forever #5 ref_clk = ~ref_clk;
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] b);
      txDataReg = b;
      txDataRegWrite = 1'h1;
      cyc(1);
      txDataRegWrite = 1'h0;
   endtask
   task automatic rd;
      rxRead = 1'h1;
      startDetectClear = 1'h1;
      cyc(1);
      rxRead = 1'h0;
      startDetectClear = 1'h0;
      cyc(1);
   endtask
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         uartLine = i == 0 ? 1'h0 : i == 9 ? 1'h1 : b[i - 1];
         cyc(16);
      end
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      void'($urandom(45788));
      cyc(8);
      rst = 1'h0;
      chk({dataRegEmpty, txDirectionOut}, 8'h02);
      // A write with the transmitter off is dropped, so no clock may start.
      txEnable = 1'h0;
      wr(8'h5a);
      cyc(2);
      chk({dataRegEmpty, transferClockPinOut}, 8'h02);
      txEnable = 1'h1;
      for (int k = 0; k < 8; k++) begin
         {clockPhaseSel, bitOrderSel} = k[1:0];
         slaveTx = 8'($urandom);
         got = k == 4 ? 8'hff : k == 5 ? 8'h00 : 8'($urandom);
         load = 1'h1;
         cyc(1);
         load = 1'h0;
         wr(got);
         for (c = 0; rxCompleteFlag !== 1'h1 && c < 500; c++) cyc(1);
         if (c == 500) n_fail++;
         cyc(1);
         chk(rxData, slaveTx);
         chk(slaveRx, got);
         chk({frameError, bufferOverflow, rxIrq}, 8'h01);
         chk({transferClockPinOeN, txdOeN}, 8'h00);
         rd();
      end
      spiMode = 1'h0;
      baudDivisor = 16'h0000;
      lineDriverMode = 2'h1;
      cyc(4);
      wr(8'hc5);
      for (c = 0; txDirectionOut !== 1'h1 && c < 99; c++) cyc(1);
      for (c = 0; txdOut !== 1'h0 && c < 99; c++) cyc(1);
      chk(c[7:0], 8'h10);
      for (c = 0; txDirectionOut === 1'h1 && c < 400; c++) begin
         if (c % 16 == 8 && c > 16 && c < 150) got = {txdOut, got[7:1]};
         cyc(1);
      end
      chk(got, 8'hc5);
      chk(8'(c > 175 && c < 178), 8'h01);
      chk(txdOeN, 8'h00);
      lineDriverMode = 2'h2;
      cyc(2);
      chk(txdOeN, 8'h01);
      lineDriverMode = 2'h0;
      sleepMode = 2'h2;
      startDetectEnable = 1'h1;
      cyc(20);
      chk({oscRequest, serialClkEnable}, 8'h00);
      uartLine = 1'h0;
      cyc(3);
      uartLine = 1'h1;
      cyc(3);
      chk({oscRequest, serialClkEnable, startDetectFlag}, 8'h07);
      cyc(30);
      chk({oscRequest, serialClkEnable}, 8'h00);
      rd();
      startDetectIntEn = 1'h0;
      send(8'h96);
      cyc(8);
      chk(rxData, 8'h96);
      chk({rxCompleteFlag, wakeRequest}, 8'h03);
      rd();
      sleepMode = 2'h0;
      send(8'h3c);
      cyc(8);
      chk({startDetectFlag, rxCompleteFlag}, 8'h01);
      report_and_stop();
   end
endmodule // tb_top
